// *** hdl/fpx_flash_protect.sv ***
/*
 * fpx_flash_protect: serial-side write protection check and upper
 * address byte of a serial NOR flash. assumes the host drives the
 * serial pins asynchronously to clk_i, far slower than clk_i, and that
 * status bits and lock writes come from logic on clk_i.
 */
`timescale 1ns/1ps
// Operation
// - inverted range protects the complement of blocks
// - protected target discards erase or program
// - lock bits count only with per-block scheme
// - all lock bits set after power up
// - volatile upper address byte register kept
// - C8h reads, C5h writes upper address byte
// - upper byte used only in 3-byte mode
// - upper byte bits 1:0 pick 16MB region
// - 4-byte instructions use received upper byte
// - wide default or B7h forces 4-byte addressing
// - received fourth byte never changes register
// - register cleared by every kind of reset
// - scheme select picks range or lock protection
// - partial final byte cancels write commands
module fpx_flash_protect import fpx_pkg::*; #(
    parameter int NUM_BLK = 1 << BLK_W // number of 64KB blocks
) (
    input wire logic clk_i, // 10 MHz block clock
    input wire logic rst_i, // power-up reset, high
    input wire logic cs_n_i, // chip select pin, low active
    input wire logic sck_i, // serial clock pin
    input wire logic di_i, // serial data in pin
    input wire logic hw_reset_n_i, // hardware reset pin, low active
    input wire logic soft_rst_done_i, // software reset finished, pulse
    input wire logic protect_scheme_select_i, // 1 = per-block locks
    input wire logic range_invert_i, // invert protected range
    input wire logic top_or_bottom_select_i, // 1 = range at bottom
    input wire logic [3:0] range_size_i, // range size code
    input wire logic powerup_wide_address_default_i, // start in 4-byte mode
    input wire logic lock_we_i, // lock bit write strobe
    input wire logic [BLK_W-1:0] lock_blk_i, // lock bit index
    input wire logic lock_val_i, // lock bit value
    output logic do_o, // serial data out
    output logic do_oe_n_o, // data out enable, low drives
    output logic op_start_o, // accepted erase/program, pulse
    output logic op_reject_o, // discarded erase/program, pulse
    output logic [7:0] op_cmd_o, // instruction of the operation
    output logic [31:0] op_addr_o, // full target address
    output logic address_width_state_o, // 1 = 4-byte addressing
    output logic [7:0] upper_address_byte_o // upper address byte
);
    // pin synchronisers; stage 1 feeds only stage 2
    logic cs_q1, cs_q2, cs_q3;
    logic sck_q1, sck_q2, sck_q3;
    logic di_q1, di_q2;
    logic rn_q1, rn_q2;
    // frame state
    fpx_state_t state_reg, state_next;
    logic [2:0] bit_reg, bit_next; // bits of current byte
    logic [2:0] byte_reg, byte_next; // completed bytes, saturating
    logic [7:0] shift_reg, shift_next; // incoming byte
    logic [7:0] cmd_reg, cmd_next; // instruction byte
    logic [31:0] addr_reg, addr_next; // received address bytes
    logic [7:0] tx_reg, tx_next; // outgoing byte
    logic do_reg, do_next;
    logic oe_n_reg, oe_n_next;
    // held configuration
    logic [7:0] uab_reg, uab_next; // upper address byte
    logic ads_reg, ads_next; // 4-byte addressing active
    logic pend_reg, pend_next; // reload mode default next cycle
    logic [NUM_BLK-1:0] lock_reg, lock_next; // per-block lock bits
    // operation report
    logic start_reg, start_next;
    logic reject_reg, reject_next;
    logic [7:0] op_cmd_reg, op_cmd_next;
    logic [31:0] op_addr_reg, op_addr_next;
    // decode helpers
    logic sck_rise, sck_fall, cs_rise, clr, wide, deny, hit, any;
    logic is4b, is_pe, is_chip, addr_done, len_ok, frame_end;
    logic [7:0] byte_in;
    logic [2:0] naddr;
    logic [31:0] eff_addr;

    // two flops on each pin before any logic looks at it
    always_ff @(posedge clk_i) begin
        cs_q1 <= cs_n_i;
        cs_q2 <= cs_q1;
        cs_q3 <= cs_q2;
        sck_q1 <= sck_i;
        sck_q2 <= sck_q1;
        sck_q3 <= sck_q2;
        di_q1 <= di_i;
        di_q2 <= di_q1;
        rn_q1 <= hw_reset_n_i;
        rn_q2 <= rn_q1;
    end

    // edges of the sampled pins, and the combined clear
    always_comb begin
        sck_rise = ~cs_q2 & sck_q2 & ~sck_q3;
        sck_fall = ~cs_q2 & ~sck_q2 & sck_q3;
        cs_rise = cs_q2 & ~cs_q3;
        clr = ~rn_q2 | soft_rst_done_i;
        byte_in = {shift_reg[6:0], di_q2};
        frame_end = cs_rise & (state_reg != ST_IDLE);
        len_ok = (bit_reg == 3'h0);
    end

    // instruction classes and the address actually targeted
    always_comb begin
        is4b = (cmd_reg == CMD_PP4) | (cmd_reg == CMD_SE4) | (cmd_reg == CMD_BE64_4);
        is_chip = (cmd_reg == CMD_CE_A) | (cmd_reg == CMD_CE_B);
        is_pe = is4b | is_chip | (cmd_reg == CMD_PP) | (cmd_reg == CMD_SE)
            | (cmd_reg == CMD_BE32) | (cmd_reg == CMD_BE64);
        wide = ads_reg | is4b;
        naddr = wide ? ADDR_BYTES_WIDE : ADDR_BYTES_NARROW;
        // upper byte replaces the missing fourth byte only when narrow
        eff_addr = wide ? addr_reg : {uab_reg, addr_reg[23:0]};
        addr_done = is_chip ? (byte_reg != 3'h0) : (byte_reg > naddr);
        deny = is_chip ? any : hit;
    end

    fpx_prot_decode #(
        .BW(BLK_W)
    ) fpx_prot_decode_inst (
        .scheme_i(protect_scheme_select_i),
        .invert_i(range_invert_i),
        .bottom_i(top_or_bottom_select_i),
        .size_i(range_size_i),
        .blk_i(eff_addr[BLK_LSB +: BLK_W]),
        .lock_bit_i(lock_reg[eff_addr[BLK_LSB +: BLK_W]]),
        .lock_any_i(|lock_reg),
        .hit_o(hit),
        .any_o(any)
    );

    // serial frame: bit and byte counting, address capture, read-out
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        shift_next = shift_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        tx_next = tx_reg;
        do_next = do_reg;
        oe_n_next = oe_n_reg;
        case (state_reg)
            ST_IDLE: begin
                oe_n_next = 1'b1; // released between frames
                if (!cs_q2) begin
                    state_next = ST_CMD;
                    bit_next = 3'h0;
                    byte_next = 3'h0;
                end
            end
            ST_CMD: begin
                if (sck_rise) begin
                    shift_next = byte_in;
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        cmd_next = byte_in;
                        byte_next = 3'h1;
                        state_next = ST_BODY;
                        tx_next = uab_reg;
                    end
                end
            end
            ST_BODY: begin
                if (sck_rise) begin
                    shift_next = byte_in;
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        if (byte_reg != BYTE_CNT_MAX) begin
                            byte_next = byte_reg + 3'h1;
                        end
                        // separate from uab_reg, so a fourth byte cannot touch it
                        if (byte_reg <= naddr) begin
                            addr_next = {addr_reg[23:0], byte_in};
                        end
                    end
                end
                if (sck_fall && cmd_reg == CMD_RD_UAB) begin
                    do_next = tx_reg[7];
                    tx_next = {tx_reg[6:0], tx_reg[7]};
                    oe_n_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (cs_q2) begin
            state_next = ST_IDLE; // chip select high ends any frame
            oe_n_next = 1'b1;
        end
    end

    // upper address byte, address mode and lock bits
    always_comb begin
        uab_next = uab_reg;
        ads_next = ads_reg;
        pend_next = 1'b0;
        lock_next = lock_reg;
        if (lock_we_i) begin
            lock_next[lock_blk_i] = lock_val_i;
        end
        if (clr) begin
            uab_next = UAB_RESET;
            ads_next = 1'b0;
            pend_next = 1'b1;
            lock_next = '1;
        end else if (pend_reg) begin
            ads_next = powerup_wide_address_default_i;
        end else if (frame_end && len_ok) begin
            if (cmd_reg == CMD_WR_UAB && byte_reg >= 3'h2) begin
                uab_next = addr_reg[7:0];
            end
            if (cmd_reg == CMD_EN4B && byte_reg == 3'h1) begin
                ads_next = 1'b1;
            end
        end
    end

    // erase/program acceptance at the end of the frame
    always_comb begin
        start_next = 1'b0;
        reject_next = 1'b0;
        op_cmd_next = op_cmd_reg;
        op_addr_next = op_addr_reg;
        if (frame_end && len_ok && is_pe && addr_done && !clr) begin
            op_cmd_next = cmd_reg;
            op_addr_next = eff_addr;
            if (deny) begin
                reject_next = 1'b1;
            end else begin
                start_next = 1'b1;
            end
        end
    end

    // register every group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            bit_reg <= 3'h0;
            byte_reg <= 3'h0;
            shift_reg <= 8'h00;
            cmd_reg <= 8'h00;
            addr_reg <= 32'h00000000;
            tx_reg <= 8'h00;
            do_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            uab_reg <= UAB_RESET;
            ads_reg <= 1'b0;
            pend_reg <= 1'b1;
            lock_reg <= '1;
            start_reg <= 1'b0;
            reject_reg <= 1'b0;
            op_cmd_reg <= 8'h00;
            op_addr_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            shift_reg <= shift_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            tx_reg <= tx_next;
            do_reg <= do_next;
            oe_n_reg <= oe_n_next;
            uab_reg <= uab_next;
            ads_reg <= ads_next;
            pend_reg <= pend_next;
            lock_reg <= lock_next;
            start_reg <= start_next;
            reject_reg <= reject_next;
            op_cmd_reg <= op_cmd_next;
            op_addr_reg <= op_addr_next;
        end
    end

    assign do_o = do_reg;
    assign do_oe_n_o = oe_n_reg;
    assign op_start_o = start_reg;
    assign op_reject_o = reject_reg;
    assign op_cmd_o = op_cmd_reg;
    assign op_addr_o = op_addr_reg;
    assign address_width_state_o = ads_reg;
    assign upper_address_byte_o = uab_reg;

    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_pe_end;
        frame_end && len_ok && is_pe && addr_done && !clr;
    endsequence
    sequence s_wr_uab;
        frame_end && len_ok && !clr && cmd_reg == CMD_WR_UAB && byte_reg >= 3'h2;
    endsequence

    AST_INV_TOP_ONE: assert property (
        (!protect_scheme_select_i && range_invert_i && !top_or_bottom_select_i
            && range_size_i == 4'h1)
        |-> hit == (eff_addr[BLK_LSB +: BLK_W] != {BLK_W{1'b1}}))
        else $error("inverted range decode wrong");
    AST_DENY_DROPS: assert property (
        (s_pe_end and deny) |=> reject_reg && !start_reg)
        else $error("protected operation not discarded");
    AST_LOCK_SCHEME: assert property (
        protect_scheme_select_i |-> hit == lock_reg[eff_addr[BLK_LSB +: BLK_W]])
        else $error("lock bit ignored under per-block scheme");
    AST_LOCK_INIT: assert property (
        $fell(rst_i) |-> &lock_reg)
        else $error("lock bits not all set after reset");
    AST_UAB_WRITE: assert property (
        s_wr_uab |=> uab_reg == $past(addr_reg[7:0]))
        else $error("upper byte write lost");
    AST_READ_OUT: assert property (
        (sck_fall && state_reg == ST_BODY && cmd_reg == CMD_RD_UAB && !cs_q2)
        |=> !do_oe_n_o && do_o == $past(tx_reg[7]))
        else $error("upper byte read bit wrong");
    AST_REGION: assert property (
        (s_pe_end and !wide) |=> op_addr_reg[31:24] == $past(uab_reg))
        else $error("narrow address region wrong");
    AST_OWN_UPPER: assert property (
        (s_pe_end and is4b) |=> op_addr_reg[31:24] == $past(addr_reg[31:24]))
        else $error("4-byte instruction upper byte wrong");
    AST_EN4B: assert property (
        (frame_end && len_ok && !clr && !pend_reg && cmd_reg == CMD_EN4B
            && byte_reg == 3'h1) |=> ads_reg ##1 ads_reg || clr)
        else $error("wide mode not entered");
    AST_UAB_HOLD: assert property (
        !(frame_end && len_ok && cmd_reg == CMD_WR_UAB && byte_reg >= 3'h2) && !clr
        |=> $stable(uab_reg))
        else $error("upper byte changed without a write");
    AST_UAB_CLEAR: assert property (
        clr |=> uab_reg == UAB_RESET)
        else $error("upper byte not cleared by reset");
    AST_PARTIAL_BYTE: assert property (
        (frame_end && !len_ok) |=> !start_reg && !reject_reg && $stable(uab_reg))
        else $error("partial byte frame acted on");
    AST_NO_START_IF_DENY: assert property (
        start_reg |-> !$past(deny))
        else $error("operation started on protected span");
endmodule // fpx_flash_protect

// *** hdl/fpx_pkg.sv ***
/*
 * fpx_pkg: constants for the flash protection and upper address block.
 * assumes a single 10 MHz clock domain; no timing counts are needed.
 */
package fpx_pkg;
    // instruction codes handled by this block
    localparam logic [7:0] CMD_WR_UAB = 8'hC5; // write upper address byte
    localparam logic [7:0] CMD_RD_UAB = 8'hC8; // read upper address byte
    localparam logic [7:0] CMD_EN4B = 8'hB7; // enter wide address mode
    localparam logic [7:0] CMD_PP = 8'h02; // page program
    localparam logic [7:0] CMD_PP4 = 8'h12; // page program, own upper byte
    localparam logic [7:0] CMD_SE = 8'h20; // 4KB erase
    localparam logic [7:0] CMD_SE4 = 8'h21; // 4KB erase, own upper byte
    localparam logic [7:0] CMD_BE32 = 8'h52; // 32KB erase
    localparam logic [7:0] CMD_BE64 = 8'hD8; // 64KB erase
    localparam logic [7:0] CMD_BE64_4 = 8'hDC; // 64KB erase, own upper byte
    localparam logic [7:0] CMD_CE_A = 8'hC7; // chip erase
    localparam logic [7:0] CMD_CE_B = 8'h60; // chip erase, alias
    // array geometry
    localparam int BLK_W = 10; // 1024 blocks of 64KB
    localparam int BLK_LSB = 16; // block index starts at address bit 16
    localparam logic [3:0] BP_ALL_MIN = 4'hB; // range codes from here cover all
    localparam logic [7:0] UAB_RESET = 8'h00; // upper address byte after reset
    localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3; // 3-byte addressing
    localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4; // 4-byte addressing
    localparam logic [2:0] BYTE_CNT_MAX = 3'h7; // byte counter saturation
    // frame state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CMD = 3'h2,
        ST_BODY = 3'h4
    } fpx_state_t;
endpackage

// *** hdl/fpx_prot_decode.sv ***
/*
 * fpx_prot_decode: decides whether one 64KB block, and any block at all,
 * is write protected. assumes its inputs are stable in the clk_i domain.
 */
`timescale 1ns/1ps
module fpx_prot_decode import fpx_pkg::*; #(
    parameter int BW = BLK_W // block index width
) (
    input wire logic scheme_i, // 1 = per-block locks
    input wire logic invert_i, // invert the range
    input wire logic bottom_i, // 1 = range from block 0 upward
    input wire logic [3:0] size_i, // range size code
    input wire logic [BW-1:0] blk_i, // block being checked
    input wire logic lock_bit_i, // lock bit of that block
    input wire logic lock_any_i, // any lock bit set
    output logic hit_o, // block is protected
    output logic any_o // some block is protected
);
    localparam logic [BW:0] NUM = (BW+1)'(1) << BW; // number of blocks
    logic [BW:0] span; // blocks in the plain range
    logic range_hit; // block inside the plain range

    // range decode, then optional inversion or per-block locks
    always_comb begin
        span = (BW+1)'(1) << (size_i - 4'h1);
        if (size_i == 4'h0) begin
            range_hit = 1'b0; // nothing in range
        end else if (size_i >= BP_ALL_MIN) begin
            range_hit = 1'b1; // whole array
        end else if (bottom_i) begin
            range_hit = {1'b0, blk_i} < span;
        end else begin
            range_hit = {1'b0, blk_i} >= (NUM - span);
        end
        if (scheme_i) begin
            hit_o = lock_bit_i;
            any_o = lock_any_i;
        end else begin
            hit_o = range_hit ^ invert_i;
            any_o = invert_i ? (size_i < BP_ALL_MIN) : (size_i != 4'h0);
        end
    end
endmodule // fpx_prot_decode

// *** sim/fpx_host_model.sv ***
/*
 * fpx_host_model: serial host that clocks frames into the flash block.
 * assumes clk_i is the 10 MHz block clock; sck runs at clk_i / 8.
 */
`timescale 1ns/1ps
module fpx_host_model (
    input wire logic clk_i, // block clock, pacing only
    input wire logic do_i, // data out line, pulled up
    output logic cs_n_o, // chip select, low active
    output logic sck_o, // serial clock, idle low
    output logic di_o // serial data to the device
);
    // idle pins at time zero
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        di_o = 1'b0;
    end

    // n bits of b go out msb first; rd keeps the last 8 bits read back
    // caller passes the opcode, then 3 or 4 address bytes as the mode asks
    task automatic xfer(input logic [63:0] b, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            di_o = b[63-i]; // set up while sck is low
            repeat (4) @(negedge clk_i);
            sck_o = 1'b1;
            repeat (4) @(negedge clk_i);
            rd = {rd[6:0], do_i}; // late read, device shifts well after the fall
            sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        // n is whole bytes except where a cut frame is meant
        cs_n_o = 1'b1;
        di_o = ~di_o; // released line shows no stale value
        repeat (8) @(negedge clk_i); // gap between frames
    endtask
endmodule // fpx_host_model

// *** sim/fpx_flash_protect_test.sv ***
/*
 * fpx_flash_protect_test: self-checking bench for the protection and
 * upper address block. assumes fpx_host_model drives the serial pins.
 */
`timescale 1ns/1ps
module fpx_flash_protect_test import fpx_pkg::*;;
    typedef struct packed {
        logic r; // refusal expected
        logic [7:0] c; // instruction
        logic [31:0] a; // full address
        logic ca; // address worth comparing
    } fpx_exp_t;
    logic clk_i = 1'b0; // 10 MHz
    logic rst_i = 1'b1; // power-up reset
    logic hw_reset_n = 1'b1; // hardware reset pin
    logic srd = 1'b0; // software reset done
    logic scheme = 1'b0, inv = 1'b0, bottom = 1'b0, wide = 1'b0;
    logic [3:0] sz = 4'h0; // range size code
    logic lwe = 1'b0, lval = 1'b0;
    logic [9:0] lblk = 10'h000;
    logic [1023:0] lk = '1; // lock bit model
    logic [7:0] ub = 8'h00; // upper byte model
    logic wm = 1'b0; // wide mode model
    logic [7:0] cmds [7] = '{CMD_PP, CMD_PP4, CMD_SE, CMD_SE4, CMD_BE32, CMD_BE64, CMD_BE64_4};
    wire cs_n, sck, di, do_w, oe_n, st, rj, aws;
    wire [7:0] cmd, uab;
    wire [31:0] addr;
    wire do_line = oe_n ? 1'b1 : do_w; // pull-up when released
    fpx_exp_t expq[$];
    fpx_exp_t e;
    int n_fail = 0, total_checks = 0, cyc = 0, seed;
    logic [31:0] k;
    logic [7:0] d;

    fpx_flash_protect fpx_flash_protect_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sck_i(sck), .di_i(di),
        .hw_reset_n_i(hw_reset_n), .soft_rst_done_i(srd), .protect_scheme_select_i(scheme),
        .range_invert_i(inv), .top_or_bottom_select_i(bottom), .range_size_i(sz),
        .powerup_wide_address_default_i(wide), .lock_we_i(lwe), .lock_blk_i(lblk),
        .lock_val_i(lval), .do_o(do_w), .do_oe_n_o(oe_n), .op_start_o(st),
        .op_reject_o(rj), .op_cmd_o(cmd), .op_addr_o(addr),
        .address_width_state_o(aws), .upper_address_byte_o(uab));
    fpx_host_model fpx_host_model_inst (
        .clk_i(clk_i), .do_i(do_line), .cs_n_o(cs_n), .sck_o(sck), .di_o(di));

    always #50 clk_i = ~clk_i;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [39:0] x, input logic [39:0] g);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("FAIL t=%0t exp=%h got=%h", $time, x, g);
        end
    endtask

    // protection of one block from the bench's own settings
    function automatic logic prot(input logic [9:0] b);
        int n;
        if (scheme) return lk[b];
        n = sz == 4'h0 ? 0 : (sz >= BP_ALL_MIN ? 1024 : 1 << (sz - 1));
        return (bottom ? b < n : b >= 1024 - n) ^ inv;
    endfunction

    // erase or program; narrow frames take the upper byte from the model
    task automatic op(input logic [7:0] c, input logic [31:0] a);
        logic w;
        logic [31:0] ea;
        w = wm || c == CMD_PP4 || c == CMD_SE4 || c == CMD_BE64_4;
        ea = w ? a : {ub, a[23:0]};
        expq.push_back(fpx_exp_t'{prot(ea[25:16]), c, ea, 1'b1});
        fpx_host_model_inst.xfer(w ? {c, a, 24'hA50000} : {c, a[23:0], 32'hA5000000},
            w ? 48 : 40, d);
    endtask

    // chip erase: refused if any block at all is protected
    task automatic chip(input logic [7:0] c);
        expq.push_back(fpx_exp_t'{scheme ? |lk : (inv ? sz < BP_ALL_MIN : sz != 4'h0), c,
            32'h0, 1'b0});
        fpx_host_model_inst.xfer({c, 56'h0}, 8, d);
    endtask

    task automatic set_uab(input logic [7:0] v);
        fpx_host_model_inst.xfer({CMD_WR_UAB, v, 48'h0}, 16, d);
        ub = v;
        chk(ub, uab);
        fpx_host_model_inst.xfer({CMD_RD_UAB, 56'h0}, 16, d);
        chk(ub, d);
        chk(1'b1, oe_n);
    endtask

    task automatic lock(input logic [9:0] b, input logic v);
        lblk = b;
        lval = v;
        lwe = 1'b1;
        @(negedge clk_i);
        lwe = 1'b0;
        lk[b] = v;
        @(negedge clk_i);
    endtask

    // kind 0 hardware pin, 1 software reset done, 2 power-up reset
    task automatic clr(input int t);
        if (t == 0) hw_reset_n = 1'b0;
        else if (t == 1) srd = 1'b1;
        else rst_i = 1'b1;
        repeat (t == 1 ? 1 : 5) @(negedge clk_i);
        {hw_reset_n, srd, rst_i} = 3'h4;
        repeat (8) @(negedge clk_i);
        ub = 8'h00;
        wm = wide;
        lk = '1;
        chk(8'h00, uab);
        chk(wm, aws);
    endtask

    // watcher: each pulse must match the oldest note
    // looks at the falling edge, away from the edge that launches the pulse
    always @(negedge clk_i) begin
        if (st === 1'b1 || rj === 1'b1) begin
            if (expq.size() == 0) begin
                chk(40'h0, 40'h1);
            end else begin
                e = expq.pop_front();
                chk({e.r, ~e.r, e.c}, {rj, st, cmd});
                if (e.ca) chk(e.a, addr);
            end
        end
    end

    // hang guard, well above the expected length of the run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        seed = $urandom(32'h3E95);
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk(8'h00, uab);
        chk(1'b0, aws);
        // straight after power-up every lock is set
        scheme = 1'b1;
        op(CMD_SE4, {6'h00, 10'($urandom), 16'h0});
        lock(10'h005, 1'b0);
        op(CMD_BE64_4, 32'h00050000);
        op(CMD_BE64_4, 32'h0006FFFF);
        chip(CMD_CE_A);
        // range scheme with nothing in range: locks must not matter
        scheme = 1'b0;
        op(CMD_PP4, 32'h00061234);
        chip(CMD_CE_B);
        // inverted one-block top range leaves only block 1023 free
        inv = 1'b1;
        sz = 4'h1;
        op(CMD_BE64_4, 32'h03FF0000);
        op(CMD_BE64_4, 32'h03FEFFFF);
        inv = 1'b0;
        sz = 4'h0;
        for (int u = 0; u < 4; u++) begin
            set_uab(8'(u));
            op(CMD_PP, $urandom);
            op(CMD_SE4, {8'(3 - u), 24'($urandom)});
            chk(8'(u), uab);
        end
        // random ranges, blocks often near either end of the array
        for (int i = 0; i < 24; i++) begin
            k = $urandom;
            inv = k[20];
            bottom = k[21];
            sz = k[25:22];
            if (k[10]) k[9:0] = {{7{k[0]}}, k[3:1]};
            op(cmds[k[30:28] % 7], {6'h00, k[9:0], k[15:0]});
        end
        inv = 1'b0;
        sz = 4'h0;
        // cut frames do nothing at all
        fpx_host_model_inst.xfer({CMD_BE64_4, 56'h0}, 36, d);
        fpx_host_model_inst.xfer({CMD_WR_UAB, 8'h01, 48'h0}, 12, d);
        chk(ub, uab);
        fpx_host_model_inst.xfer({CMD_EN4B, 56'h0}, 8, d);
        wm = 1'b1;
        chk(1'b1, aws);
        op(CMD_PP, {6'h00, 26'($urandom)});
        op(CMD_BE32, 32'h02000000);
        set_uab(8'h02);
        clr(0);
        wide = 1'b1;
        set_uab(8'h01);
        clr(1);
        op(CMD_SE, 32'h00010000);
        wide = 1'b0;
        clr(2);
        scheme = 1'b1;
        chip(CMD_CE_A);
        op(CMD_BE64, 32'h00123456);
        chk(40'h0, 40'(expq.size()));
        give_verdict();
    end
endmodule // fpx_flash_protect_test
